// ### rtl/data_eeprom_control_status.sv
// data eeprom control, status, unlock and register port
`timescale 1ns/1ps
`include "eeprom_ctl_defines.svh"
//
// Contract
// - the control register holds only its low four bits, the upper four read 0.
// - read and write strobes are set-only by software and cleared by hardware.
// - a write starts only while write_permit is set; power-up clears it.
// - an external clear or watchdog reset during a write sets write_error_flag.
// - any reset clears the data register and the address register.
// - a finished write sets eeprom_done_flag, which only software or power-up reset clears.
// - the unlock port stores nothing, reads 0, and only sequences writes.

module data_eeprom_control_status #(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ext_clear_in,
  input wire logic wdt_reset_in,
  input wire logic [`EE_ADDR_W-1:0] addr_in,
  input wire eeprom_ctl_pkg::byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output eeprom_ctl_pkg::byte_t rdata_out,
  output logic write_busy_out
);
  import eeprom_ctl_pkg::*;

  function automatic logic hit(input logic [`EE_ADDR_W-1:0] a,
                               input logic [`EE_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic read_strobe_ff;
  logic write_strobe_ff;
  logic write_permit_ff;
  logic write_error_flag_ff;
  logic eeprom_done_flag_ff;
  byte_t eeprom_data_reg_ff;
  byte_t eeprom_address_reg_ff;
  byte_t rdata_ff;
  unlock_state_t unlock_ff;

  logic nxt_read_strobe;
  logic nxt_write_strobe;
  logic nxt_write_permit;
  logic nxt_write_error_flag;
  logic nxt_eeprom_done_flag;
  byte_t nxt_eeprom_data_reg;
  byte_t nxt_eeprom_address_reg;
  byte_t nxt_rdata;
  unlock_state_t nxt_unlock;

  byte_t arr_rdata;
  logic arr_busy;
  logic arr_done;

  // external clear and watchdog act as resets that keep the array
  wire warm_reset = ext_clear_in || wdt_reset_in;

  wire sel_control = hit(addr_in, `EE_OFF_CONTROL);
  wire sel_unlock = hit(addr_in, `EE_OFF_UNLOCK);
  wire sel_data = hit(addr_in, `EE_OFF_DATA);
  wire sel_address = hit(addr_in, `EE_OFF_ADDRESS);
  wire sel_flags = hit(addr_in, `EE_OFF_FLAGS);

  wire control_wr = wr_in && sel_control;
  wire unlock_wr = wr_in && sel_unlock;
  wire data_wr = wr_in && sel_data;
  wire address_wr = wr_in && sel_address;
  wire flags_wr = wr_in && sel_flags;

  // a write only starts straight after the two-key unlock sequence
  wire write_go = control_wr && wdata_in[`EE_BIT_WRITE] &&
                  write_permit_ff && (unlock_ff == UL_ARMED) &&
                  !write_strobe_ff;

  wire [7:0] control_view = {4'h0, write_error_flag_ff, write_permit_ff,
                             write_strobe_ff, read_strobe_ff};
  wire [7:0] flags_view = {eeprom_done_flag_ff, 7'h00};

  // unmapped addresses and the unlock port read back zero
  wire [7:0] read_mux = sel_control ? control_view :
                        sel_data ? eeprom_data_reg_ff :
                        sel_address ? eeprom_address_reg_ff :
                        sel_flags ? flags_view :
                        `EE_RST_BYTE;

  assign nxt_rdata = rd_in ? read_mux : `EE_RST_BYTE;

  // software can only raise the read strobe; it drops after one load
  assign nxt_read_strobe = read_strobe_ff ? 1'b0 :
                           (control_wr && wdata_in[`EE_BIT_READ]);

  // a zero written to the write strobe is ignored, so no early abort
  assign nxt_write_strobe = write_go ||
                            (write_strobe_ff && !arr_done);

  assign nxt_write_permit = control_wr ? wdata_in[`EE_BIT_PERMIT] :
                            write_permit_ff;
  assign nxt_write_error_flag = control_wr ? wdata_in[`EE_BIT_WERR] :
                                write_error_flag_ff;

  // completion wins over a software clear in the same cycle
  assign nxt_eeprom_done_flag = arr_done ||
                                (flags_wr ? wdata_in[`EE_BIT_DONE] :
                                 eeprom_done_flag_ff);

  // the read load takes priority over a software store that same cycle
  assign nxt_eeprom_data_reg = read_strobe_ff ? arr_rdata :
                               data_wr ? wdata_in :
                               eeprom_data_reg_ff;
  assign nxt_eeprom_address_reg = address_wr ? wdata_in :
                                  eeprom_address_reg_ff;

  // any bus write other than the next key or the first key breaks the sequence
  always_comb begin
    nxt_unlock = unlock_ff;
    if (unlock_wr) begin
      if (unlock_ff == UL_KEY1 && wdata_in == `EE_KEY_SECOND) begin
        nxt_unlock = UL_ARMED;
      end else if (wdata_in == `EE_KEY_FIRST) begin
        nxt_unlock = UL_KEY1;
      end else begin
        nxt_unlock = UL_IDLE;
      end
    end else if (wr_in) begin
      nxt_unlock = UL_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      read_strobe_ff <= 1'b0;
      write_strobe_ff <= 1'b0;
      write_permit_ff <= 1'b0;
      write_error_flag_ff <= `EE_RST_WERR;
      eeprom_done_flag_ff <= 1'b0;
      unlock_ff <= UL_IDLE;
      rdata_ff <= `EE_RST_BYTE;
    end else if (warm_reset) begin
      read_strobe_ff <= 1'b0;
      write_strobe_ff <= 1'b0;
      write_permit_ff <= 1'b0;
      // a write whose last cycle already landed is finished, not cut
      write_error_flag_ff <= write_error_flag_ff ||
                             (write_strobe_ff && !arr_done);
      eeprom_done_flag_ff <= eeprom_done_flag_ff || arr_done;
      unlock_ff <= UL_IDLE;
      rdata_ff <= `EE_RST_BYTE;
    end else begin
      read_strobe_ff <= nxt_read_strobe;
      write_strobe_ff <= nxt_write_strobe;
      write_permit_ff <= nxt_write_permit;
      write_error_flag_ff <= nxt_write_error_flag;
      eeprom_done_flag_ff <= nxt_eeprom_done_flag;
      unlock_ff <= nxt_unlock;
      rdata_ff <= nxt_rdata;
    end
  end

  // software must reload both after any reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in || warm_reset) begin
      eeprom_data_reg_ff <= `EE_RST_BYTE;
      eeprom_address_reg_ff <= `EE_RST_BYTE;
    end else begin
      eeprom_data_reg_ff <= nxt_eeprom_data_reg;
      eeprom_address_reg_ff <= nxt_eeprom_address_reg;
    end
  end

  assign rdata_out = rdata_ff;
  assign write_busy_out = write_strobe_ff;

  // array latches address and data at start, later edits do not leak in
  eeprom_array #(
    .DEPTH(DEPTH),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) eeprom_array_i (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .abort_in(warm_reset),
    .start_in(write_go && !warm_reset),
    .addr_in(eeprom_address_reg_ff),
    .wdata_in(eeprom_data_reg_ff),
    .rdata_out(arr_rdata),
    .busy_out(arr_busy),
    .done_out(arr_done)
  );

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  AST_CONTROL_UPPER_ZERO:
    assert property (rd_in && sel_control |=> rdata_out[7:4] == 4'h0)
    else $error("control upper bits not zero");

  AST_READ_STROBE_SELF_CLEAR:
    assert property (read_strobe_ff |=> !read_strobe_ff)
    else $error("read strobe not cleared after one cycle");

  AST_WRITE_STROBE_HOLDS:
    assert property (write_strobe_ff && !arr_done && !warm_reset
                     |=> write_strobe_ff)
    else $error("write strobe dropped before completion");

  AST_WRITE_NEEDS_PERMIT:
    assert property ($rose(write_strobe_ff) |-> $past(write_permit_ff))
    else $error("write started without permit");

  AST_PERMIT_CLEAR_AT_POWERUP:
    assert property ($past(reset_in) |-> !write_permit_ff)
    else $error("permit set after power-up");

  AST_ABORT_SETS_ERROR:
    assert property (warm_reset && write_strobe_ff && !arr_done
                     |=> write_error_flag_ff && !write_strobe_ff)
    else $error("aborted write did not flag error");

  AST_WARM_RESET_CLEARS_REGS:
    assert property (warm_reset |=> eeprom_data_reg_ff == 8'h00 &&
                     eeprom_address_reg_ff == 8'h00)
    else $error("data or address not cleared by reset");

  AST_DONE_FLAG_SET:
    assert property (write_strobe_ff && arr_done
                     |=> eeprom_done_flag_ff && !write_strobe_ff)
    else $error("write completion did not set done flag");

  AST_DONE_FLAG_STICKY:
    assert property (eeprom_done_flag_ff && !flags_wr
                     |=> eeprom_done_flag_ff)
    else $error("done flag cleared without software");

  AST_UNLOCK_READS_ZERO:
    assert property (rd_in && sel_unlock |=> rdata_out == 8'h00)
    else $error("unlock port did not read zero");

  AST_READ_LOADS_DATA:
    assert property (read_strobe_ff && !warm_reset
                     |=> eeprom_data_reg_ff == $past(arr_rdata))
    else $error("read strobe did not load data");

  AST_WRITE_BOUNDED:
    assert property ($rose(write_strobe_ff) |-> arr_busy
                     ##[1:1000] !write_strobe_ff)
    else $error("write did not finish in time");

  // the checks below look at register state and bus inputs, never at the bench
  AST_STROBES_READ_BACK:
    assert property (rd_in && sel_control && !warm_reset
                     |=> rdata_out[1] == $past(write_strobe_ff) &&
                         rdata_out[0] == $past(read_strobe_ff))
    else $error("strobe bits not visible in control");

  AST_READ_STROBE_SET:
    assert property (control_wr && wdata_in[`EE_BIT_READ] &&
                     !read_strobe_ff && !warm_reset |=> read_strobe_ff)
    else $error("read strobe not set by software");

  AST_SW_CANNOT_CLEAR_WRITE:
    assert property (control_wr && !wdata_in[`EE_BIT_WRITE] &&
                     write_strobe_ff && !arr_done && !warm_reset
                     |=> write_strobe_ff)
    else $error("software cleared the write strobe");

  // the array never runs without the strobe showing it
  AST_BUSY_HAS_STROBE:
    assert property (arr_busy |-> write_strobe_ff)
    else $error("array busy while write strobe low");

  AST_NO_PERMIT_NO_WRITE:
    assert property (control_wr && !write_permit_ff && !write_strobe_ff
                     |=> !write_strobe_ff)
    else $error("write strobe set without permit");

  AST_ERROR_KEPT_ON_WARM:
    assert property (warm_reset && write_error_flag_ff
                     |=> write_error_flag_ff)
    else $error("warm reset lost the write error flag");

  AST_NO_ERROR_WITHOUT_WRITE:
    assert property (warm_reset && !write_strobe_ff && !write_error_flag_ff
                     |=> !write_error_flag_ff)
    else $error("write error flagged with no write running");

  AST_POWERUP_CLEARS_REGS:
    assert property ($past(reset_in) |-> eeprom_data_reg_ff == 8'h00 &&
                     eeprom_address_reg_ff == 8'h00)
    else $error("data or address not cleared by power reset");

  AST_DONE_SW_CLEAR:
    assert property (flags_wr && !wdata_in[`EE_BIT_DONE] && !arr_done &&
                     !warm_reset |=> !eeprom_done_flag_ff)
    else $error("software could not clear done flag");

  AST_DONE_ONLY_ON_FINISH:
    assert property (!eeprom_done_flag_ff && !arr_done && !flags_wr
                     |=> !eeprom_done_flag_ff)
    else $error("done flag set without a finished write");

  // key writes must leave the data, address and permit registers untouched
  AST_UNLOCK_STORES_NOTHING:
    assert property (unlock_wr && !read_strobe_ff && !warm_reset
                     |=> $stable(eeprom_data_reg_ff) &&
                         $stable(eeprom_address_reg_ff) &&
                         $stable(write_permit_ff))
    else $error("unlock port write changed stored state");
endmodule // data_eeprom_control_status

// ### rtl/eeprom_array.sv
// data eeprom byte array with a timed, abortable programming cycle
`timescale 1ns/1ps
`include "eeprom_ctl_defines.svh"

module eeprom_array #(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic abort_in,
  input wire logic start_in,
  input wire logic [7:0] addr_in,
  input wire eeprom_ctl_pkg::byte_t wdata_in,
  output eeprom_ctl_pkg::byte_t rdata_out,
  output logic busy_out,
  output logic done_out
);
  import eeprom_ctl_pkg::*;

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  byte_t mem [DEPTH];
  write_state_t state_ff;
  logic [CW-1:0] count_ff;
  logic [7:0] waddr_ff;
  byte_t wdata_ff;
  logic done_ff;

  wire last_cycle = (state_ff == WS_BUSY) && (count_ff == '0);

  assign rdata_out = mem[addr_in];
  assign busy_out = (state_ff == WS_BUSY);
  assign done_out = done_ff;

  // contents survive every reset; only the sequencer is cleared
  always_ff @(posedge core_clk_in) begin
    if (last_cycle && !abort_in && !reset_in) begin
      mem[waddr_ff] <= wdata_ff;
    end
  end

  // an aborted cycle leaves the old byte in place
  always_ff @(posedge core_clk_in) begin
    if (reset_in || abort_in) begin
      state_ff <= WS_IDLE;
      count_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= last_cycle;
      unique case (state_ff)
        WS_IDLE: begin
          if (start_in) begin
            state_ff <= WS_BUSY;
            count_ff <= CW'(WRITE_CYCLES - 1);
          end
        end
        WS_BUSY: begin
          if (last_cycle) begin
            state_ff <= WS_IDLE;
          end else begin
            count_ff <= count_ff - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (start_in && state_ff == WS_IDLE) begin
      waddr_ff <= addr_in;
      wdata_ff <= wdata_in;
    end
  end
endmodule // eeprom_array

// ### rtl/eeprom_ctl_defines.svh
// register offsets, bit positions, reset values and timing for eeprom control
`ifndef EEPROM_CTL_DEFINES_SVH
`define EEPROM_CTL_DEFINES_SVH

`define EE_ADDR_W 3
`define EE_OFF_CONTROL 3'h0
`define EE_OFF_UNLOCK 3'h1
`define EE_OFF_DATA 3'h2
`define EE_OFF_ADDRESS 3'h3
`define EE_OFF_FLAGS 3'h4

`define EE_BIT_READ 0
`define EE_BIT_WRITE 1
`define EE_BIT_PERMIT 2
`define EE_BIT_WERR 3
`define EE_BIT_DONE 7

`define EE_RST_BYTE 8'h00
`define EE_RST_WERR 1'b0

`define EE_KEY_FIRST 8'h5a
`define EE_KEY_SECOND 8'ha5

`define EE_CLK_PERIOD_NS 50
`define EE_WRITE_TIME_NS 2000
`define EE_WRITE_CYCLES \
  ((`EE_WRITE_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)

`endif

// ### rtl/eeprom_ctl_pkg.sv
// types shared by the eeprom control block
package eeprom_ctl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} unlock_state_t;
  typedef enum logic {WS_IDLE, WS_BUSY} write_state_t;
endpackage

// ### verification/data_eeprom_control_status_tb_top.sv
// self-checking bench for the data eeprom control and status block
`timescale 1ns/1ps
`include "eeprom_ctl_defines.svh"

module data_eeprom_control_status_tb_top;
  import eeprom_ctl_pkg::*;
  // short programming time keeps the run brief but leaves room to abort
  localparam int WCYC = 6;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ext_clear_in = 1'b0;
  logic wdt_reset_in = 1'b0;
  logic [`EE_ADDR_W-1:0] addr_in = '0;
  byte_t wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  byte_t rdata_out;
  logic write_busy_out;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'd53113;
  byte_t got;
  byte_t ea;
  byte_t ed;

  data_eeprom_control_status #(.DEPTH(256), .WRITE_CYCLES(WCYC))
    data_eeprom_control_status_i (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ext_clear_in(ext_clear_in),
    .wdt_reset_in(wdt_reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .write_busy_out(write_busy_out)
  );

  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end

  function automatic byte_t rnd_byte();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input byte_t g, input byte_t e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle strobes with a gap so a strobe is never driven twice per step
  task automatic wr(input logic [`EE_ADDR_W-1:0] a, input byte_t d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [`EE_ADDR_W-1:0] a, output byte_t v);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    @(negedge core_clk_in);
    v = rdata_out;
  endtask

  task automatic ee_start(input byte_t a, input byte_t d, input byte_t p);
    wr(`EE_OFF_ADDRESS, a);
    wr(`EE_OFF_DATA, d);
    wr(`EE_OFF_CONTROL, p);
    wr(`EE_OFF_UNLOCK, `EE_KEY_FIRST);
    wr(`EE_OFF_UNLOCK, `EE_KEY_SECOND);
    wr(`EE_OFF_CONTROL, p | 8'h02);
  endtask

  task automatic ee_read(input byte_t a, output byte_t v);
    wr(`EE_OFF_ADDRESS, a);
    wr(`EE_OFF_CONTROL, 8'h01);
    repeat (2) @(posedge core_clk_in);
    rd(`EE_OFF_DATA, v);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      @(negedge core_clk_in);
      if (write_busy_out === 1'b0) return;
    end
    err_total++;
    tally_and_finish();
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(`EE_OFF_CONTROL, got);
    chk(got, 8'h00);
    wr(`EE_OFF_CONTROL, 8'hf4);
    rd(`EE_OFF_CONTROL, got);
    chk(got, 8'h04);
    wr(`EE_OFF_UNLOCK, rnd_byte());
    rd(`EE_OFF_UNLOCK, got);
    chk(got, 8'h00);
    ea = rnd_byte();
    ed = rnd_byte();
    wr(`EE_OFF_ADDRESS, ea);
    rd(`EE_OFF_ADDRESS, got);
    chk(got, ea);
    // no permit: the strobe must be refused
    ee_start(ea, ed, 8'h00);
    @(negedge core_clk_in);
    chk({7'h00, write_busy_out}, 8'h00);
    ee_start(ea, ed, 8'h04);
    @(negedge core_clk_in);
    chk({7'h00, write_busy_out}, 8'h01);
    rd(`EE_OFF_FLAGS, got);
    chk(got & 8'h80, 8'h00);
    wr(`EE_OFF_CONTROL, 8'h04);
    @(negedge core_clk_in);
    chk({7'h00, write_busy_out}, 8'h01);
    wait_idle();
    rd(`EE_OFF_CONTROL, got);
    chk(got & 8'h02, 8'h00);
    repeat (3) @(posedge core_clk_in);
    rd(`EE_OFF_FLAGS, got);
    chk(got & 8'h80, 8'h80);
    wr(`EE_OFF_FLAGS, 8'h00);
    rd(`EE_OFF_FLAGS, got);
    chk(got & 8'h80, 8'h00);
    ee_read(ea, got);
    chk(got, ed);
    rd(`EE_OFF_CONTROL, got);
    chk(got, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ee_start(ea, ~ed, 8'h04);
      @(posedge core_clk_in);
      if (k == 0) ext_clear_in <= 1'b1;
      else wdt_reset_in <= 1'b1;
      @(posedge core_clk_in);
      ext_clear_in <= 1'b0;
      wdt_reset_in <= 1'b0;
      @(negedge core_clk_in);
      chk({7'h00, write_busy_out}, 8'h00);
      rd(`EE_OFF_CONTROL, got);
      chk(got, 8'h08);
      rd(`EE_OFF_DATA, got);
      chk(got, 8'h00);
      rd(`EE_OFF_ADDRESS, got);
      chk(got, 8'h00);
      rd(`EE_OFF_FLAGS, got);
      chk(got & 8'h80, 8'h00);
      wr(`EE_OFF_CONTROL, 8'h00);
      rd(`EE_OFF_CONTROL, got);
      chk(got, 8'h00);
      ee_read(ea, got);
      chk(got, ed);
    end
    // idle watchdog reset has no write to cut, so no error may appear
    @(posedge core_clk_in);
    wdt_reset_in <= 1'b1;
    @(posedge core_clk_in);
    wdt_reset_in <= 1'b0;
    rd(`EE_OFF_CONTROL, got);
    chk(got, 8'h00);
    tally_and_finish();
  end
endmodule // data_eeprom_control_status_tb_top
